// >>> usdc_pkg.sv
package usdc_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned SUSP_IDLE_US = 3000;
	localparam int unsigned WAKE_HOLDOFF_US = 5000;
	localparam int unsigned K_DRIVE_US = 5000;
	localparam int unsigned K_MIN_US = 1000;
	localparam int unsigned K_MAX_US = 15000;
	localparam int unsigned WAKE_DEADLINE_US = 10000;
	localparam int unsigned SUSP_IDLE_CYC = SUSP_IDLE_US * CLK_MHZ;
	localparam int unsigned WAKE_HOLDOFF_CYC = WAKE_HOLDOFF_US * CLK_MHZ;
	localparam int unsigned K_DRIVE_CYC = K_DRIVE_US * CLK_MHZ;
	localparam int unsigned K_MIN_CYC = K_MIN_US * CLK_MHZ;
	localparam int unsigned K_MAX_CYC = K_MAX_US * CLK_MHZ;
	localparam int unsigned WAKE_DEADLINE_CYC = WAKE_DEADLINE_US * CLK_MHZ;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_FRAME = 12'h000;
	localparam logic [11:0] OFS_GLOBAL = 12'h004;
	localparam logic [11:0] OFS_FADDR = 12'h008;
	localparam logic [11:0] OFS_IRQ_SET = 12'h010;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h014;
	localparam logic [11:0] OFS_IRQ_VIEW = 12'h018;
	localparam logic [11:0] OFS_IRQ_PEND = 12'h01c;
	localparam logic [11:0] OFS_IRQ_ACK = 12'h020;
	localparam logic [11:0] OFS_EP_RESET = 12'h028;
	localparam logic [11:0] OFS_EP_CSR = 12'h030;
	localparam logic [11:0] OFS_EP_FIFO = 12'h050;
	localparam logic [11:0] OFS_TXVC = 12'h074;
	localparam int unsigned MAX_EP = 8;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned GLB_ADDR_EN = 0;
	localparam int unsigned GLB_CONFIG = 1;
	localparam int unsigned GLB_RESUME = 2;
	localparam int unsigned GLB_RMW_EN = 4;
	localparam int unsigned FADDR_W = 7;
	localparam int unsigned FADDR_FEN = 8;
	localparam int unsigned FRAME_W = 11;
	localparam int unsigned FRAME_ERR = 16;
	localparam int unsigned FRAME_OK = 17;
	localparam int unsigned IRQ_SUSP = 8;
	localparam int unsigned IRQ_RSM = 9;
	localparam int unsigned IRQ_SOF = 11;
	localparam int unsigned IRQ_WAKE = 13;
	localparam logic [31:0] IRQ_MASK_BITS = 32'h0000_2bff;
	localparam int unsigned TXVC_DIS = 8;
	localparam int unsigned TXVC_PULLUP = 9;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] FADDR_RST = 32'h0000_0100;
	localparam logic [31:0] IMR_RST = 32'h0000_1200;
	localparam logic [31:0] TXVC_RST = 32'h0000_0100;

	// ----------------------------------------
	// bus encodings
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic frame_start_pid;
		logic frame_start_packet_end;
		logic sof_bad;
		logic [FRAME_W-1:0] frame;
	} usdc_sie_s;

	typedef struct packed {
		logic txv_disable;
		logic pullup_on;
		logic drive_k;
	} usdc_phy_s;

	typedef enum {
		RW_IDLE,
		RW_HOLD,
		RW_DRIVE
	} usdc_wake_e;

endpackage

// >>> usdc_sync.sv
`timescale 1ns/100ps
module usdc_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// level crossing
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// >>> usdc_top.sv
// Notes on behaviour
// - suspend sets flag; interrupt only if masked-in
// - acknowledge clears suspend flag; then suspend entered
// - resume seen while suspended; pull-up stays
// - resume sets wakeup flag; interrupt if enabled
// - transceiver disable bit switches transceiver off
// - no remote wakeup before 5 ms suspended
// - K state within 10 ms of wake start
// - K state lasts 1 to 15 ms
// - K only on zero-to-one send-resume write
// - K generated and released without software
// - endpoint control words from 0x030 onward
// - endpoint fifo words from 0x050 onward; not decoded here, they read as zero
// - frame number captured at frame packet end
// - bit 16 frame error, cleared on frame pid
// - bit 17 frame good, cleared on frame pid
// - frame interrupt raised at frame pid
// - trigger needs previous zero and remote enable
// - seven-bit function address, resets to zero
`timescale 1ns/100ps
module usdc_top #(
	parameter int unsigned NUM_EP = usdc_pkg::MAX_EP,
	parameter int unsigned SUSP_IDLE_CYC = usdc_pkg::SUSP_IDLE_CYC,
	parameter int unsigned WAKE_HOLDOFF_CYC = usdc_pkg::WAKE_HOLDOFF_CYC,
	parameter int unsigned K_DRIVE_CYC = usdc_pkg::K_DRIVE_CYC
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// ahb-lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	// link side
	input wire logic BUS_ACTIVITY_IN,
	input wire usdc_pkg::usdc_sie_s SIE_IN,
	output usdc_pkg::usdc_phy_s PHY_OUT,
	// device state
	output logic [usdc_pkg::FADDR_W-1:0] DEV_ADDR_OUT,
	output logic FUNC_EN_OUT,
	output logic ADDR_STATE_OUT,
	output logic CONFIGURED_OUT,
	output logic SUSPENDED_OUT,
	output logic IRQ_OUT
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (NUM_EP < 1 || NUM_EP > usdc_pkg::MAX_EP) begin : g_bad_ep
		$error("NUM_EP must be 1 to 8");
	end
	if (SUSP_IDLE_CYC < 2 || WAKE_HOLDOFF_CYC < 1 || K_DRIVE_CYC < 1) begin : g_bad_time
		$error("timing counts too small");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
		in_bank = (a >= base) && (a < base + 12'(NUM_EP * 4));
	endfunction

	function automatic logic [2:0] bank_idx(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		bank_idx = d[4:2];
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [11:0] addr_q;
	logic wr_q;
	logic act_q;
	logic rd_done_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_val;
	logic accept;
	logic hready_int;
	logic wen;
	logic [usdc_pkg::FADDR_W-1:0] faddr_q;
	logic fen_q;
	logic addr_en_q;
	logic config_q;
	logic resume_bit_q;
	logic rmw_en_q;
	logic [31:0] imr_q;
	logic [31:0] isr_q;
	logic [31:0] isr_set;
	logic [31:0] isr_clr;
	logic [7:0] ep_reset_q;
	logic [31:0] ep_csr_q [NUM_EP];
	logic txv_dis_q;
	logic pullup_q;
	logic [usdc_pkg::FRAME_W-1:0] frame_q;
	logic frame_err_q;
	logic frame_ok_q;
	logic act_sync;
	logic [31:0] idle_cnt_q;
	logic susp_pend_q;
	logic suspended_q;
	logic susp_event;
	logic wake_event;
	logic [31:0] age_q;
	logic [31:0] k_cnt_q;
	usdc_pkg::usdc_wake_e wake_q;
	logic drive_k_q;
	logic trigger;
	logic irq_q;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// resume is only visible through the pad detector; this path needs the clock running
	usdc_sync #(
		.WIDTH(1)
	) u_act_sync (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.async_in(BUS_ACTIVITY_IN),
		.sync_out(act_sync)
	);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// reads take one wait state so a write in the previous data phase is seen
	assign accept = HSEL_IN && HREADY_IN && (HTRANS_IN == usdc_pkg::HTRANS_NONSEQ);
	assign hready_int = !(act_q && !wr_q && !rd_done_q);
	assign wen = act_q && wr_q;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			addr_q <= 12'h000;
			wr_q <= 1'b0;
			act_q <= 1'b0;
		end else if (accept) begin
			addr_q <= {HADDR_IN[11:2], 2'b00};
			wr_q <= HWRITE_IN;
			act_q <= 1'b1;
		end else if (hready_int) begin
			act_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			rd_done_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			rd_done_q <= act_q && !wr_q && !rd_done_q;
			if (act_q && !wr_q && !rd_done_q) begin
				hrdata_q <= rd_val;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (addr_q)
			usdc_pkg::OFS_FRAME: begin
				rd_val[usdc_pkg::FRAME_W-1:0] = frame_q;
				rd_val[usdc_pkg::FRAME_ERR] = frame_err_q;
				rd_val[usdc_pkg::FRAME_OK] = frame_ok_q;
			end
			usdc_pkg::OFS_GLOBAL: begin
				rd_val[usdc_pkg::GLB_ADDR_EN] = addr_en_q;
				rd_val[usdc_pkg::GLB_CONFIG] = config_q;
				rd_val[usdc_pkg::GLB_RESUME] = resume_bit_q;
				rd_val[usdc_pkg::GLB_RMW_EN] = rmw_en_q;
			end
			usdc_pkg::OFS_FADDR: begin
				rd_val[usdc_pkg::FADDR_W-1:0] = faddr_q;
				rd_val[usdc_pkg::FADDR_FEN] = fen_q;
			end
			usdc_pkg::OFS_IRQ_VIEW: rd_val = imr_q;
			usdc_pkg::OFS_IRQ_PEND: rd_val = isr_q;
			usdc_pkg::OFS_EP_RESET: rd_val[7:0] = ep_reset_q;
			usdc_pkg::OFS_TXVC: begin
				rd_val[usdc_pkg::TXVC_DIS] = txv_dis_q;
				rd_val[usdc_pkg::TXVC_PULLUP] = pullup_q;
			end
			default: begin
				if (in_bank(addr_q, usdc_pkg::OFS_EP_CSR)) begin
					rd_val = ep_csr_q[bank_idx(addr_q, usdc_pkg::OFS_EP_CSR)];
				end
			end
		endcase
	end

	// ----------------------------------------
	// device state registers
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			faddr_q <= usdc_pkg::FADDR_RST[usdc_pkg::FADDR_W-1:0];
			fen_q <= usdc_pkg::FADDR_RST[usdc_pkg::FADDR_FEN];
		end else if (wen && addr_q == usdc_pkg::OFS_FADDR) begin
			faddr_q <= HWDATA_IN[usdc_pkg::FADDR_W-1:0];
			fen_q <= HWDATA_IN[usdc_pkg::FADDR_FEN];
		end
	end

	// address enable only falls at reset; writing zero has no effect
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			addr_en_q <= 1'b0;
			config_q <= 1'b0;
			resume_bit_q <= 1'b0;
			rmw_en_q <= 1'b0;
		end else if (wen && addr_q == usdc_pkg::OFS_GLOBAL) begin
			addr_en_q <= addr_en_q || HWDATA_IN[usdc_pkg::GLB_ADDR_EN];
			config_q <= HWDATA_IN[usdc_pkg::GLB_CONFIG];
			resume_bit_q <= HWDATA_IN[usdc_pkg::GLB_RESUME];
			rmw_en_q <= HWDATA_IN[usdc_pkg::GLB_RMW_EN];
		end
	end

	// only a zero-to-one move of the send-resume bit, with remote enable, starts wakeup
	assign trigger = wen && addr_q == usdc_pkg::OFS_GLOBAL
		&& HWDATA_IN[usdc_pkg::GLB_RESUME] && !resume_bit_q
		&& HWDATA_IN[usdc_pkg::GLB_RMW_EN];

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			txv_dis_q <= usdc_pkg::TXVC_RST[usdc_pkg::TXVC_DIS];
			pullup_q <= usdc_pkg::TXVC_RST[usdc_pkg::TXVC_PULLUP];
		end else if (wen && addr_q == usdc_pkg::OFS_TXVC) begin
			txv_dis_q <= HWDATA_IN[usdc_pkg::TXVC_DIS];
			pullup_q <= HWDATA_IN[usdc_pkg::TXVC_PULLUP];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ep_reset_q <= 8'h00;
		end else if (wen && addr_q == usdc_pkg::OFS_EP_RESET) begin
			ep_reset_q <= HWDATA_IN[7:0];
		end
	end

	// fifo words are not decoded and hold no storage here; they read as zero
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			for (int i = 0; i < NUM_EP; i++) begin
				ep_csr_q[i] <= 32'h0000_0000;
			end
		end else if (wen && in_bank(addr_q, usdc_pkg::OFS_EP_CSR)) begin
			ep_csr_q[bank_idx(addr_q, usdc_pkg::OFS_EP_CSR)] <= HWDATA_IN;
		end
	end

	// ----------------------------------------
	// interrupt mask and status
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			imr_q <= usdc_pkg::IMR_RST;
		end else if (wen && addr_q == usdc_pkg::OFS_IRQ_SET) begin
			imr_q <= imr_q | (HWDATA_IN & usdc_pkg::IRQ_MASK_BITS);
		end else if (wen && addr_q == usdc_pkg::OFS_IRQ_CLR) begin
			imr_q <= imr_q & ~(HWDATA_IN & usdc_pkg::IRQ_MASK_BITS);
		end
	end

	always_comb begin
		isr_set = 32'h0000_0000;
		isr_set[usdc_pkg::IRQ_SUSP] = susp_event;
		isr_set[usdc_pkg::IRQ_RSM] = wake_event;
		isr_set[usdc_pkg::IRQ_WAKE] = wake_event;
		isr_set[usdc_pkg::IRQ_SOF] = SIE_IN.frame_start_pid;
		isr_clr = 32'h0000_0000;
		if (wen && addr_q == usdc_pkg::OFS_IRQ_ACK) begin
			isr_clr = HWDATA_IN;
		end
	end

	// a new event in the clearing cycle survives
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			isr_q <= 32'h0000_0000;
		end else begin
			isr_q <= (isr_q & ~isr_clr) | isr_set;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(isr_q & imr_q);
		end
	end

	// ----------------------------------------
	// frame tracker
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			frame_q <= '0;
			frame_err_q <= 1'b0;
			frame_ok_q <= 1'b0;
		end else if (SIE_IN.frame_start_packet_end) begin
			frame_q <= SIE_IN.frame;
			frame_err_q <= SIE_IN.sof_bad;
			frame_ok_q <= !SIE_IN.sof_bad;
		end else if (SIE_IN.frame_start_pid) begin
			frame_err_q <= 1'b0;
			frame_ok_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// suspend and resume
	// ----------------------------------------
	// our own K state would look like host resume, so activity is ignored while driving
	assign susp_event = !suspended_q && !susp_pend_q && act_sync == 1'b0
		&& idle_cnt_q == SUSP_IDLE_CYC - 1;
	assign wake_event = suspended_q && act_sync && !drive_k_q;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			idle_cnt_q <= 32'h0000_0000;
		end else if (act_sync || suspended_q || susp_pend_q) begin
			idle_cnt_q <= 32'h0000_0000;
		end else if (idle_cnt_q != SUSP_IDLE_CYC - 1) begin
			idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			susp_pend_q <= 1'b0;
			suspended_q <= 1'b0;
		end else if (susp_event) begin
			susp_pend_q <= 1'b1;
		end else if (susp_pend_q && act_sync) begin
			susp_pend_q <= 1'b0;
		end else if (susp_pend_q && !isr_q[usdc_pkg::IRQ_SUSP]) begin
			susp_pend_q <= 1'b0;
			suspended_q <= 1'b1;
		end else if (wake_event) begin
			suspended_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// remote wakeup
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			age_q <= 32'h0000_0000;
		end else if (!suspended_q) begin
			age_q <= 32'h0000_0000;
		end else if (age_q < WAKE_HOLDOFF_CYC) begin
			age_q <= age_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			wake_q <= usdc_pkg::RW_IDLE;
			k_cnt_q <= 32'h0000_0000;
			drive_k_q <= 1'b0;
		end else begin
			case (wake_q)
				usdc_pkg::RW_IDLE: begin
					if (trigger && suspended_q) begin
						wake_q <= usdc_pkg::RW_HOLD;
					end
				end
				usdc_pkg::RW_HOLD: begin
					if (!suspended_q) begin
						wake_q <= usdc_pkg::RW_IDLE;
					end else if (age_q >= WAKE_HOLDOFF_CYC) begin
						wake_q <= usdc_pkg::RW_DRIVE;
						k_cnt_q <= 32'h0000_0000;
						drive_k_q <= 1'b1;
					end
				end
				usdc_pkg::RW_DRIVE: begin
					if (k_cnt_q == K_DRIVE_CYC - 1) begin
						wake_q <= usdc_pkg::RW_IDLE;
						drive_k_q <= 1'b0;
					end else begin
						k_cnt_q <= k_cnt_q + 32'h0000_0001;
					end
				end
				default: begin
					wake_q <= usdc_pkg::RW_IDLE;
					drive_k_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign HRDATA_OUT = hrdata_q;
	assign HREADYOUT_OUT = hready_int;
	assign HRESP_OUT = 1'b0;
	assign PHY_OUT.txv_disable = txv_dis_q;
	assign PHY_OUT.pullup_on = pullup_q;
	assign PHY_OUT.drive_k = drive_k_q;
	assign DEV_ADDR_OUT = faddr_q;
	assign FUNC_EN_OUT = fen_q;
	assign ADDR_STATE_OUT = addr_en_q;
	assign CONFIGURED_OUT = config_q;
	assign SUSPENDED_OUT = suspended_q;
	assign IRQ_OUT = irq_q;
endmodule

// >>> usdc_monitor.sv
`timescale 1ns/100ps
module usdc_monitor #(
	parameter int unsigned WAKE_HOLDOFF_CYC = 30,
	parameter int unsigned K_DRIVE_CYC = 10
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// register bus
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic HREADY_IN,
	input wire logic HREADYOUT_OUT,
	// link and state
	input wire logic BUS_ACTIVITY_IN,
	input wire usdc_pkg::usdc_phy_s PHY_OUT,
	input wire logic [usdc_pkg::FADDR_W-1:0] DEV_ADDR_OUT,
	input wire logic SUSPENDED_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic taken;
	logic txv_wr;
	logic [31:0] k_cnt_q;
	logic [31:0] s_cnt_q;
	assign taken = HSEL_IN && HREADY_IN && HTRANS_IN == usdc_pkg::HTRANS_NONSEQ;
	assign txv_wr = taken && HWRITE_IN && HADDR_IN[11:0] == usdc_pkg::OFS_TXVC;
	// wide counts: full-length timings must not wrap
	always_ff @(posedge CLK_IN) begin
		k_cnt_q <= PHY_OUT.drive_k ? k_cnt_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge CLK_IN) begin
		s_cnt_q <= SUSPENDED_OUT ? s_cnt_q + 32'h1 : 32'h0;
	end
	sequence s_read_taken;
		taken && !HWRITE_IN;
	endsequence
	sequence s_one_wait;
		!HREADYOUT_OUT ##1 HREADYOUT_OUT;
	endsequence
	a_read_wait: assert property (s_read_taken |=> s_one_wait)
		else $error("read wait state wrong");
	a_write_ready: assert property (taken && HWRITE_IN |=> HREADYOUT_OUT)
		else $error("write stalled");
	a_k_length: assert property ($fell(PHY_OUT.drive_k) |-> k_cnt_q == K_DRIVE_CYC)
		else $error("k state length wrong");
	a_wake_holdoff: assert property ($rose(PHY_OUT.drive_k)
		|-> s_cnt_q >= WAKE_HOLDOFF_CYC - 1)
		else $error("k state too soon after suspend");
	a_txv_follows: assert property ($changed(PHY_OUT.txv_disable) |->
		$past(txv_wr, 2) || $past(txv_wr, 3))
		else $error("transceiver changed without a write");
	a_resume_seen: assert property (SUSPENDED_OUT && BUS_ACTIVITY_IN
		&& !PHY_OUT.drive_k |-> ##[1:4] !SUSPENDED_OUT)
		else $error("resume not seen");
	a_addr_reset: assert property ($rose(RST_N_IN) |-> DEV_ADDR_OUT == 7'h0)
		else $error("address not zero after reset");
	a_pullup_kept: assert property ($rose(SUSPENDED_OUT) |-> $stable(PHY_OUT.pullup_on))
		else $error("pull-up dropped at suspend");
endmodule

// >>> usdc_host_model.sv
`timescale 1ns/100ps
module usdc_host_model (
	// clock
	input wire logic clk_in,
	// link toward the device
	output logic activity_out,
	output usdc_pkg::usdc_sie_s sie_out
);
	initial begin
		activity_out = 1'b1;
		sie_out = '0;
	end
	task set_activity(input logic on);
		@(posedge clk_in);
		activity_out <= on;
	endtask
	// frame field shows the inverse outside its strobe, never a stale match
	task sof(input logic [10:0] f, input logic bad, input logic with_eop);
		@(posedge clk_in);
		sie_out <= {3'b100, ~f};
		@(posedge clk_in);
		sie_out <= {3'b000, ~f};
		repeat (3) @(posedge clk_in);
		if (with_eop) begin
			sie_out <= {2'b01, bad, f};
			@(posedge clk_in);
			sie_out <= {3'b000, ~f};
		end
	endtask
endmodule

// >>> usdc_top_bench.sv
`timescale 1ns/100ps
module usdc_top_bench;
	localparam int unsigned HOLD = 30;
	localparam int unsigned KLEN = 10;
	localparam logic [11:0] RA[10] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h018,
		12'h01c, 12'h028, 12'h04c, 12'h050, 12'h074};
	localparam logic [31:0] RV[10] = '{32'h0, 32'h0, 32'h100, 32'h0, 32'h1200,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h100};
	logic clk, rst_n, hsel, hwrite, rd_q, hreadyout, act, irq, susp, function_enable_bit, astate, conf;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, cyc, wn, v;
	logic [10:0] f;
	logic [6:0] dev_addr;
	usdc_pkg::usdc_sie_s sie;
	usdc_pkg::usdc_phy_s phy;
	logic [31:0] exp_q[$];
	int miscompares, n_compared;
	usdc_top #(.SUSP_IDLE_CYC(20), .WAKE_HOLDOFF_CYC(HOLD), .K_DRIVE_CYC(KLEN)) dut (
		.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
		.HRESP_OUT(), .BUS_ACTIVITY_IN(act), .SIE_IN(sie), .PHY_OUT(phy),
		.DEV_ADDR_OUT(dev_addr), .FUNC_EN_OUT(function_enable_bit), .ADDR_STATE_OUT(astate),
		.CONFIGURED_OUT(conf), .SUSPENDED_OUT(susp), .IRQ_OUT(irq));
	usdc_host_model host (.clk_in(clk), .activity_out(act), .sie_out(sie));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 32'h1;
	// ----------------------------------------
	// checking
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	always @(posedge clk) if (rd_q && hreadyout) chk(hrdata, exp_q.pop_front(), "read");
	task test_done;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#(4 * 20000);
		miscompares++;
		$display("wrong value at %0t: run timed out", $time);
		test_done;
	end
	// ----------------------------------------
	// bus and waits
	// ----------------------------------------
	// entered right after an edge; holds each phase until ready is sampled high
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= usdc_pkg::HTRANS_NONSEQ;
		haddr <= {20'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_q <= !wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_q <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	function logic sig(input int s);
		return s == 0 ? irq : (s == 1 ? susp : phy.drive_k);
	endfunction
	task waitfor(input int s, input logic val, input int lim, input logic hit);
		wn = 0;
		while (sig(s) !== val && wn < lim) begin
			@(posedge clk);
			wn++;
		end
		chk({31'h0, wn < lim}, {31'h0, hit}, "wait");
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		v = $urandom(32'h25cb);
		{hsel, hwrite, rd_q, htrans, haddr, hwdata, cyc} = '0;
		hsize = 3'h2;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 10; i++) rd(RA[i], RV[i]);
		chk({25'h0, dev_addr}, 32'h0, "address");
		$display("test reset values done");
		v = $urandom & 32'h7f;
		bus(1'b1, 12'h004, 32'h1);
		bus(1'b1, 12'h008, 32'h100 | v);
		bus(1'b1, 12'h004, 32'h3);
		rd(12'h008, 32'h100 | v);
		chk({22'h0, function_enable_bit, astate, conf, dev_addr}, {25'h7, v[6:0]}, "state");
		v = $urandom;
		bus(1'b1, 12'h04c, v);
		rd(12'h04c, v);
		$display("test address state done");
		f = $urandom;
		host.sof(f, 1'b0, 1'b1);
		rd(12'h000, {14'h0, 2'b10, 5'h0, f});
		bus(1'b1, 12'h020, 32'h800);
		host.sof(f + 11'h1, 1'b1, 1'b1);
		rd(12'h000, {14'h0, 2'b01, 5'h0, f + 11'h1});
		bus(1'b1, 12'h020, 32'h800);
		host.sof(f + 11'h2, 1'b0, 1'b0);
		rd(12'h000, {14'h0, 2'b00, 5'h0, f + 11'h1});
		rd(12'h01c, 32'h800);
		bus(1'b1, 12'h020, 32'h800);
		$display("test frame capture done");
		bus(1'b1, 12'h074, 32'h200);
		host.set_activity(1'b0);
		repeat (40) @(posedge clk);
		rd(12'h01c, 32'h100);
		chk({31'h0, irq}, 32'h0, "masked");
		bus(1'b1, 12'h010, 32'h100);
		waitfor(0, 1'b1, 6, 1'b1);
		rd(12'h018, 32'h1300);
		bus(1'b1, 12'h074, 32'h300);
		bus(1'b1, 12'h020, 32'h100);
		waitfor(1, 1'b1, 4, 1'b1);
		rd(12'h01c, 32'h0);
		chk({30'h0, phy.txv_disable, phy.pullup_on}, 32'h3, "phy");
		$display("test suspend done");
		bus(1'b1, 12'h014, 32'h100);
		host.set_activity(1'b1);
		waitfor(1, 1'b0, 8, 1'b1);
		rd(12'h01c, 32'h2200);
		chk({31'h0, irq}, 32'h1, "wake irq");
		bus(1'b1, 12'h020, 32'h2200);
		bus(1'b1, 12'h074, 32'h200);
		$display("test host resume done");
		bus(1'b1, 12'h004, 32'h14);
		waitfor(2, 1'b1, HOLD + 10, 1'b0);
		bus(1'b1, 12'h004, 32'h0);
		host.set_activity(1'b0);
		repeat (30) @(posedge clk);
		bus(1'b1, 12'h020, 32'h100);
		waitfor(1, 1'b1, 4, 1'b1);
		bus(1'b1, 12'h004, 32'h4);
		bus(1'b1, 12'h004, 32'h14);
		waitfor(2, 1'b1, HOLD + 10, 1'b0);
		bus(1'b1, 12'h004, 32'h10);
		bus(1'b1, 12'h004, 32'h14);
		waitfor(2, 1'b1, 4, 1'b1);
		waitfor(2, 1'b0, KLEN + 4, 1'b1);
		chk(wn, KLEN, "k length");
		host.set_activity(1'b1);
		waitfor(1, 1'b0, 8, 1'b1);
		$display("test remote wakeup done");
		test_done;
	end
endmodule
bind usdc_top usdc_monitor #(.WAKE_HOLDOFF_CYC(WAKE_HOLDOFF_CYC), .K_DRIVE_CYC(K_DRIVE_CYC)) mon (
	.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
	.HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
	.HREADYOUT_OUT(HREADYOUT_OUT), .BUS_ACTIVITY_IN(BUS_ACTIVITY_IN), .PHY_OUT(PHY_OUT),
	.DEV_ADDR_OUT(DEV_ADDR_OUT), .SUSPENDED_OUT(SUSPENDED_OUT));
